// [design/aoe_pkg.sv]
// Shared constants and types for the operator data entry receiver.
package aoe_pkg;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_ESC = 8'h1B;
  localparam logic [7:0] CHAR_BSL = 8'h5C;
  localparam logic [7:0] CHAR_MINUS = 8'h2D;
  localparam logic [7:0] CHAR_0 = 8'h30;
  localparam logic [7:0] CHAR_9 = 8'h39;
  localparam logic [1:0] PORT_AUX = 2'h2;
  localparam logic [7:0] FIELD3_ENTRY = 8'h00;
  localparam logic [1:0] CI_OFF = 2'h0;
  localparam logic [1:0] CI_ENTER = 2'h1;
  localparam logic [1:0] CI_ANY = 2'h2;
  localparam logic [1:0] CI_CLEAR = 2'h3;
  localparam logic [2:0] STAT_DIS = 3'h7;
  localparam logic [2:0] STAT_NONE = 3'h0;
  localparam logic [2:0] STAT_CHARS = 3'h1;
  localparam logic [2:0] STAT_STRING = 3'h2;
  localparam logic [2:0] STAT_NUMBER = 3'h3;
  localparam logic [2:0] STR_LEN = 3'h6;
  localparam logic [31:0] RADIX = 32'h0000000A;
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam logic [47:0] RST_STRING = 48'h000000000000;
  localparam logic [31:0] RST_NUMBER = 32'h00000000;
  localparam logic [2:0] RST_CNT = 3'h0;

  typedef enum logic [2:0] {
    IRQ_IDLE = 3'b001,
    IRQ_ARMED = 3'b010,
    IRQ_SERVICE = 3'b100
  } aoe_irq_state_t;

  typedef struct packed {
    logic numeric;
    logic [31:0] value;
  } aoe_num_t;
endpackage

// [design/aoe_num_parse.sv]
// Decimal entry parser that builds a signed value from incoming characters.
`timescale 1ns/1ns
module aoe_num_parse (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic char_valid,
  input wire logic [7:0] char_in,
  output aoe_pkg::aoe_num_t num
);
  logic [31:0] mag_reg;
  logic [31:0] mag_next;
  logic neg_reg;
  logic neg_next;
  logic dig_reg;
  logic dig_next;
  logic bad_reg;
  logic bad_next;
  logic first_reg;
  logic first_next;

  wire is_digit = (char_in >= aoe_pkg::CHAR_0) && (char_in <= aoe_pkg::CHAR_9);
  wire [7:0] digit8 = char_in - aoe_pkg::CHAR_0;
  wire [31:0] digit = {24'h000000, digit8};

  // A clear and a character in the same cycle start a fresh entry with that character.
  always_comb
  begin
    mag_next = clr ? aoe_pkg::RST_NUMBER : mag_reg;
    neg_next = clr ? 1'b0 : neg_reg;
    dig_next = clr ? 1'b0 : dig_reg;
    bad_next = clr ? 1'b0 : bad_reg;
    first_next = clr ? 1'b1 : first_reg;
    if (char_valid)
    begin
      if (first_next && char_in == aoe_pkg::CHAR_MINUS)
        neg_next = 1'b1;
      else if (is_digit)
      begin
        mag_next = mag_next * aoe_pkg::RADIX + digit;
        dig_next = 1'b1;
      end
      else
        bad_next = 1'b1;
      first_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mag_reg <= aoe_pkg::RST_NUMBER;
      neg_reg <= 1'b0;
      dig_reg <= 1'b0;
      bad_reg <= 1'b0;
      first_reg <= 1'b1;
    end
    else
    begin
      mag_reg <= mag_next;
      neg_reg <= neg_next;
      dig_reg <= dig_next;
      bad_reg <= bad_next;
      first_reg <= first_next;
    end
  end

  assign num.numeric = dig_reg && !bad_reg;
  assign num.value = neg_reg ? (32'h00000000 - mag_reg) : mag_reg;
endmodule

// [design/aoe_rx_entry.sv]
// Receive side of the auxiliary port in operator data entry mode.
// Contract
// - Entry mode configurable on port 2 only.
// - Backslash or escape leaves entry mode.
// - Config third field zero enters mode.
// - Mode works only while program runs.
// - Entry characters bypass the command path.
// - Last character updated on every arrival consumed from port 2 (entry mode or prompted input).
// - Completed text held in string register.
// - Numeric entry held in number register.
// - Status codes -1,0,1,2,3 as defined.
// - Reading string or number zeroes status.
// - Setting 0 raises no interrupt.
// - Setting 1 interrupts on enter only.
// - Setting 2 interrupts on every character.
// - Writing -1 discards buffered characters.
// - Handler return re-arms only with option.
// - Interrupt serviced only with thread 0.
// - Prompted input stalls until data stored.
`timescale 1ns/1ns
module aoe_rx_entry (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic RX_VALID,
  input wire logic [1:0] RX_PORT,
  input wire logic [7:0] RX_CHAR,
  input wire logic PROG_RUN,
  input wire logic THREAD0_RUN,
  input wire logic CFG_WR,
  input wire logic [1:0] CFG_PORT,
  input wire logic [7:0] CFG_FIELD3,
  input wire logic CI_WR,
  input wire logic [1:0] CI_VALUE,
  input wire logic STR_RD,
  input wire logic NUM_RD,
  input wire logic HANDLER_RET,
  input wire logic RET_REENABLE,
  input wire logic INPUT_REQ,
  output logic CMD_VALID,
  output logic [7:0] CMD_CHAR,
  output logic MODE_ACTIVE,
  output logic [7:0] LAST_RX_CHAR,
  output logic [47:0] RX_STRING,
  output logic [31:0] RX_NUMBER,
  output logic [2:0] RX_STATUS_CODE,
  output logic COMM_IRQ,
  output logic IRQ_ARMED,
  output logic IN_HANDLER,
  output logic PROG_STALL,
  output logic INPUT_DONE,
  output logic [31:0] INPUT_VALUE
);
  function automatic logic irq_hit(input logic [1:0] setting, input logic enter);
    irq_hit = (setting == aoe_pkg::CI_ANY) || (setting == aoe_pkg::CI_ENTER && enter);
  endfunction

  logic mode_reg;
  logic mode_next;
  logic [1:0] comm_irq_setting_reg;
  aoe_pkg::aoe_irq_state_t irq_state_reg;
  aoe_pkg::aoe_irq_state_t irq_state_next;
  logic [47:0] buf_reg;
  logic [2:0] buf_cnt_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] status_base;
  aoe_pkg::aoe_num_t num;

  wire mode_on = mode_reg && PROG_RUN;
  wire aux_char = RX_VALID && (RX_PORT == aoe_pkg::PORT_AUX);
  wire cfg_aux = CFG_WR && (CFG_PORT == aoe_pkg::PORT_AUX);
  wire cfg_enter = cfg_aux && (CFG_FIELD3 == aoe_pkg::FIELD3_ENTRY);
  wire cfg_leave = cfg_aux && (CFG_FIELD3 != aoe_pkg::FIELD3_ENTRY);
  wire consumed = mode_on || INPUT_REQ;
  wire is_enter = RX_CHAR == aoe_pkg::CHAR_CR;
  wire is_exit = (RX_CHAR == aoe_pkg::CHAR_BSL) || (RX_CHAR == aoe_pkg::CHAR_ESC);
  wire take_char = aux_char && consumed;
  wire exit_ev = aux_char && mode_on && is_exit;
  wire enter_ev = take_char && is_enter;
  wire data_ev = take_char && !is_enter && !exit_ev;
  wire entry_enter = enter_ev && mode_on;
  wire entry_data = data_ev && mode_on;
  wire rd_any = STR_RD || NUM_RD;
  wire st_done = (status_reg == aoe_pkg::STAT_STRING) || (status_reg == aoe_pkg::STAT_NUMBER);
  wire ci_clear = CI_WR && (CI_VALUE == aoe_pkg::CI_CLEAR);
  wire buf_room = buf_cnt_reg < aoe_pkg::STR_LEN;
  wire [5:0] align_sh = {aoe_pkg::STR_LEN - buf_cnt_reg, 3'h0};
  wire [47:0] str_aligned = buf_reg << align_sh;
  wire irq_fire = (irq_state_reg == aoe_pkg::IRQ_ARMED) && THREAD0_RUN && aux_char && mode_on
    && irq_hit(comm_irq_setting_reg, is_enter);

  aoe_num_parse u_parse (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .clr(enter_ev || ci_clear),
    .char_valid(data_ev),
    .char_in(RX_CHAR),
    .num(num)
  );

  always_comb
  begin
    mode_next = mode_reg;
    if (cfg_enter)
      mode_next = 1'b1;
    else if (cfg_leave || exit_ev)
      mode_next = 1'b0;
  end

  always_comb
  begin
    status_base = (status_reg == aoe_pkg::STAT_DIS) ? aoe_pkg::STAT_NONE : status_reg;
    status_next = status_base;
    if (!mode_on)
      status_next = aoe_pkg::STAT_DIS;
    else if (entry_enter)
      status_next = num.numeric ? aoe_pkg::STAT_NUMBER : aoe_pkg::STAT_STRING;
    else if (entry_data)
      status_next = aoe_pkg::STAT_CHARS;
    else if (rd_any && st_done)
      status_next = aoe_pkg::STAT_NONE;
    else if (ci_clear && status_base == aoe_pkg::STAT_CHARS)
      status_next = aoe_pkg::STAT_NONE;
  end

  always_comb
  begin
    irq_state_next = irq_state_reg;
    case (irq_state_reg)
      aoe_pkg::IRQ_IDLE:
        if (CI_WR && (CI_VALUE == aoe_pkg::CI_ENTER || CI_VALUE == aoe_pkg::CI_ANY))
          irq_state_next = aoe_pkg::IRQ_ARMED;
      aoe_pkg::IRQ_ARMED:
        if (irq_fire)
          irq_state_next = aoe_pkg::IRQ_SERVICE;
        else if (CI_WR && CI_VALUE == aoe_pkg::CI_OFF)
          irq_state_next = aoe_pkg::IRQ_IDLE;
      aoe_pkg::IRQ_SERVICE:
        if (HANDLER_RET)
          irq_state_next = RET_REENABLE ? aoe_pkg::IRQ_ARMED : aoe_pkg::IRQ_IDLE;
      default:
        irq_state_next = aoe_pkg::IRQ_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      mode_reg <= 1'b0;
      status_reg <= aoe_pkg::STAT_DIS;
      irq_state_reg <= aoe_pkg::IRQ_IDLE;
      comm_irq_setting_reg <= aoe_pkg::CI_OFF;
      COMM_IRQ <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      status_reg <= status_next;
      irq_state_reg <= irq_state_next;
      if (CI_WR && !ci_clear)
        comm_irq_setting_reg <= CI_VALUE;
      COMM_IRQ <= irq_fire;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      CMD_VALID <= 1'b0;
      CMD_CHAR <= aoe_pkg::RST_CHAR;
    end
    else
    begin
      CMD_VALID <= RX_VALID && !take_char;
      CMD_CHAR <= RX_CHAR;
    end
  end

  // Characters past the string length are dropped from the text but still parsed.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      buf_reg <= aoe_pkg::RST_STRING;
      buf_cnt_reg <= aoe_pkg::RST_CNT;
    end
    else if (data_ev && (buf_room || ci_clear))
    begin
      buf_reg <= ci_clear ? {40'h0000000000, RX_CHAR} : {buf_reg[39:0], RX_CHAR};
      buf_cnt_reg <= ci_clear ? 3'h1 : buf_cnt_reg + 3'h1;
    end
    else if (enter_ev || ci_clear)
    begin
      buf_reg <= aoe_pkg::RST_STRING;
      buf_cnt_reg <= aoe_pkg::RST_CNT;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      LAST_RX_CHAR <= aoe_pkg::RST_CHAR;
      RX_STRING <= aoe_pkg::RST_STRING;
      RX_NUMBER <= aoe_pkg::RST_NUMBER;
    end
    else
    begin
      if (take_char)
        LAST_RX_CHAR <= RX_CHAR;
      if (entry_enter)
        RX_STRING <= str_aligned;
      if (entry_enter && num.numeric)
        RX_NUMBER <= num.value;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      INPUT_DONE <= 1'b0;
      INPUT_VALUE <= aoe_pkg::RST_NUMBER;
    end
    else
    begin
      INPUT_DONE <= INPUT_REQ && enter_ev;
      if (INPUT_REQ && enter_ev)
        INPUT_VALUE <= num.value;
    end
  end

  assign PROG_STALL = INPUT_REQ && !INPUT_DONE;
  assign MODE_ACTIVE = mode_on;
  assign RX_STATUS_CODE = status_reg;
  assign IRQ_ARMED = irq_state_reg == aoe_pkg::IRQ_ARMED;
  assign IN_HANDLER = irq_state_reg == aoe_pkg::IRQ_SERVICE;

  property p_port_only;
    @(posedge SYS_CLK) disable iff (!NRST)
    CFG_WR && CFG_PORT != aoe_pkg::PORT_AUX && !mode_reg && !exit_ev |=> !mode_reg;
  endproperty
  a_port_only: assert property (p_port_only) else $error("Mode entered on wrong port.");
  property p_exit;
    @(posedge SYS_CLK) disable iff (!NRST)
    exit_ev && !CFG_WR |=> !mode_reg ##1 RX_STATUS_CODE == aoe_pkg::STAT_DIS;
  endproperty
  a_exit: assert property (p_exit) else $error("Exit character did not leave mode.");
  property p_enter_mode;
    @(posedge SYS_CLK) disable iff (!NRST)
    cfg_enter ##1 PROG_RUN |=> RX_STATUS_CODE == aoe_pkg::STAT_NONE || RX_STATUS_CODE == aoe_pkg::STAT_CHARS
      || RX_STATUS_CODE == aoe_pkg::STAT_STRING || RX_STATUS_CODE == aoe_pkg::STAT_NUMBER;
  endproperty
  a_enter_mode: assert property (p_enter_mode) else $error("Config zero did not enable mode.");
  property p_no_prog;
    @(posedge SYS_CLK) disable iff (!NRST)
    !PROG_RUN |=> RX_STATUS_CODE == aoe_pkg::STAT_DIS && !COMM_IRQ;
  endproperty
  a_no_prog: assert property (p_no_prog) else $error("Mode active without program.");
  property p_bypass;
    @(posedge SYS_CLK) disable iff (!NRST)
    aux_char && mode_on |=> !CMD_VALID && LAST_RX_CHAR == $past(RX_CHAR);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Entry character reached command path.");
  property p_entry_done;
    @(posedge SYS_CLK) disable iff (!NRST)
    entry_enter ##1 PROG_RUN |-> RX_STATUS_CODE == ($past(num.numeric) ? aoe_pkg::STAT_NUMBER : aoe_pkg::STAT_STRING)
      && RX_STRING == $past(str_aligned);
  endproperty
  a_entry_done: assert property (p_entry_done) else $error("Completed entry not reported.");
  property p_read_clear;
    @(posedge SYS_CLK) disable iff (!NRST)
    rd_any && st_done && mode_on && !take_char |=> RX_STATUS_CODE == aoe_pkg::STAT_NONE;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Status not cleared after read.");
  property p_irq_off;
    @(posedge SYS_CLK) disable iff (!NRST)
    comm_irq_setting_reg == aoe_pkg::CI_OFF |=> !COMM_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("Interrupt raised while disabled.");
  property p_irq_enter;
    @(posedge SYS_CLK) disable iff (!NRST)
    comm_irq_setting_reg == aoe_pkg::CI_ENTER && !(aux_char && is_enter) |=> !COMM_IRQ;
  endproperty
  a_irq_enter: assert property (p_irq_enter) else $error("Interrupt on non-enter character.");
  property p_irq_any;
    @(posedge SYS_CLK) disable iff (!NRST)
    IRQ_ARMED && comm_irq_setting_reg == aoe_pkg::CI_ANY && aux_char && mode_on && THREAD0_RUN
      |=> COMM_IRQ && IN_HANDLER;
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("Character did not interrupt.");
  property p_clear;
    @(posedge SYS_CLK) disable iff (!NRST)
    ci_clear && !data_ev |=> buf_cnt_reg == aoe_pkg::RST_CNT;
  endproperty
  a_clear: assert property (p_clear) else $error("Buffer not discarded.");
  property p_return;
    @(posedge SYS_CLK) disable iff (!NRST)
    IN_HANDLER && HANDLER_RET |=> IRQ_ARMED == $past(RET_REENABLE) && !IN_HANDLER;
  endproperty
  a_return: assert property (p_return) else $error("Handler return arming wrong.");
  property p_thread0;
    @(posedge SYS_CLK) disable iff (!NRST)
    !THREAD0_RUN |=> !COMM_IRQ;
  endproperty
  a_thread0: assert property (p_thread0) else $error("Interrupt without thread 0.");
  property p_prompt;
    @(posedge SYS_CLK) disable iff (!NRST)
    INPUT_REQ && aux_char && is_enter |=> INPUT_DONE && !PROG_STALL && INPUT_VALUE == $past(num.value);
  endproperty
  a_prompt: assert property (p_prompt) else $error("Prompted input not completed.");
  property p_disarm;
    @(posedge SYS_CLK) disable iff (!NRST)
    COMM_IRQ && !HANDLER_RET ##1 !HANDLER_RET |=> !COMM_IRQ && IN_HANDLER;
  endproperty
  a_disarm: assert property (p_disarm) else $error("Interrupt repeated inside handler.");
endmodule

// [tb/aoe_term_model.sv]
// Operator terminal model that types characters into the auxiliary receive path.
`timescale 1ns/1ns
module aoe_term_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [1:0] rx_port,
  output logic [7:0] rx_char
);
  initial
  begin
    rx_valid = 1'b0;
    rx_port = 2'h1;
    rx_char = 8'hA5;
  end

  // One character per call; afterwards the lines show the inverse so stale data never looks valid.
  task automatic send(input logic [1:0] port, input logic [7:0] ch);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_port = port;
    rx_char = ch;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_port = ~port;
    rx_char = ~ch;
  endtask
endmodule

// [tb/aux_port_operator_entry_receiver_tb.sv]
// Self-checking bench for the operator data entry receiver.
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module aux_port_operator_entry_receiver_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic prog_run = 1'b0;
  logic thread0_run = 1'b0;
  logic cfg_wr = 1'b0;
  logic [1:0] cfg_port = 2'h0;
  logic [7:0] cfg_field3 = 8'h00;
  logic ci_wr = 1'b0;
  logic [1:0] ci_value = 2'h0;
  logic str_rd = 1'b0;
  logic num_rd = 1'b0;
  logic handler_ret = 1'b0;
  logic ret_reenable = 1'b0;
  logic input_req = 1'b0;
  logic rx_valid;
  logic [1:0] rx_port;
  logic [7:0] rx_char;
  logic cmd_valid;
  logic [7:0] cmd_char;
  logic mode_active;
  logic [7:0] last_rx_char;
  logic [47:0] rx_string;
  logic [31:0] rx_number;
  logic [2:0] rx_status_code;
  logic comm_irq;
  logic irq_armed;
  logic in_handler;
  logic prog_stall;
  logic input_done;
  logic [31:0] input_value;
  int comparisons = 0;
  int n_mismatch = 0;
  int cycles = 0;

  always #25 sys_clk = ~sys_clk;

  aoe_term_model i_aoe_term_model (.clk(sys_clk), .rx_valid(rx_valid), .rx_port(rx_port), .rx_char(rx_char));

  aoe_rx_entry i_aoe_rx_entry (
    .SYS_CLK(sys_clk), .NRST(nrst), .RX_VALID(rx_valid), .RX_PORT(rx_port), .RX_CHAR(rx_char),
    .PROG_RUN(prog_run), .THREAD0_RUN(thread0_run), .CFG_WR(cfg_wr), .CFG_PORT(cfg_port),
    .CFG_FIELD3(cfg_field3), .CI_WR(ci_wr), .CI_VALUE(ci_value), .STR_RD(str_rd), .NUM_RD(num_rd),
    .HANDLER_RET(handler_ret), .RET_REENABLE(ret_reenable), .INPUT_REQ(input_req),
    .CMD_VALID(cmd_valid), .CMD_CHAR(cmd_char), .MODE_ACTIVE(mode_active), .LAST_RX_CHAR(last_rx_char),
    .RX_STRING(rx_string), .RX_NUMBER(rx_number), .RX_STATUS_CODE(rx_status_code), .COMM_IRQ(comm_irq),
    .IRQ_ARMED(irq_armed), .IN_HANDLER(in_handler), .PROG_STALL(prog_stall), .INPUT_DONE(input_done),
    .INPUT_VALUE(input_value)
  );

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cfg(input logic [1:0] p, input logic [7:0] f);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_port = p;
    cfg_field3 = f;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic ci(input logic [1:0] v);
    @(negedge sys_clk);
    ci_wr = 1'b1;
    ci_value = v;
    @(negedge sys_clk);
    ci_wr = 1'b0;
  endtask

  task automatic ret(input logic re);
    @(negedge sys_clk);
    handler_ret = 1'b1;
    ret_reenable = re;
    @(negedge sys_clk);
    handler_ret = 1'b0;
  endtask

  // Reads the string when s is set, else the number.
  task automatic rd(input logic s);
    @(negedge sys_clk);
    str_rd = s;
    num_rd = ~s;
    @(negedge sys_clk);
    str_rd = 1'b0;
    num_rd = 1'b0;
  endtask

  task automatic typ(input logic [1:0] p, input string s);
    for (int i = 0; i < s.len(); i++)
      i_aoe_term_model.send(p, s[i]);
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    `CHK("status", 3'h7, rx_status_code)
    prog_run = 1'b1;
    thread0_run = 1'b1;
    cfg(2'h1, 8'h00);
    @(negedge sys_clk);
    `CHK("mode", 1'b0, mode_active)
    cfg(2'h2, 8'h00);
    `CHK("mode", 1'b1, mode_active)
    @(negedge sys_clk);
    `CHK("status", 3'h0, rx_status_code)
    typ(2'h2, "5");
    `CHK("last", 8'h35, last_rx_char)
    `CHK("cmd", 1'b0, cmd_valid)
    `CHK("status", 3'h1, rx_status_code)
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("string", 48'h350000000000, rx_string)
    `CHK("number", 32'h00000005, rx_number)
    `CHK("status", 3'h3, rx_status_code)
    rd(1'b0);
    `CHK("status", 3'h0, rx_status_code)
    typ(2'h2, "-12");
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("number", 32'hFFFFFFF4, rx_number)
    typ(2'h2, "AB");
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("string", 48'h414200000000, rx_string)
    `CHK("status", 3'h2, rx_status_code)
    `CHK("number", 32'hFFFFFFF4, rx_number)
    rd(1'b1);
    `CHK("status", 3'h0, rx_status_code)
    prog_run = 1'b0;
    i_aoe_term_model.send(2'h2, 8'h51);
    `CHK("mode", 1'b0, mode_active)
    `CHK("cmd", 1'b1, cmd_valid)
    prog_run = 1'b1;
    i_aoe_term_model.send(2'h1, 8'h52);
    `CHK("cmd_char", 8'h52, cmd_char)
    `CHK("last", 8'h0D, last_rx_char)
    ci(2'h1);
    ci(2'h0);
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("irq", 1'b0, comm_irq)
    `CHK("armed", 1'b0, irq_armed)
    ci(2'h1);
    typ(2'h2, "A");
    `CHK("irq", 1'b0, comm_irq)
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("irq", 1'b1, comm_irq)
    `CHK("handler", 1'b1, in_handler)
    `CHK("armed", 1'b0, irq_armed)
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("irq", 1'b0, comm_irq)
    ret(1'b1);
    `CHK("armed", 1'b1, irq_armed)
    ci(2'h2);
    typ(2'h2, "B");
    `CHK("irq", 1'b1, comm_irq)
    ret(1'b0);
    `CHK("armed", 1'b0, irq_armed)
    typ(2'h2, "C");
    `CHK("irq", 1'b0, comm_irq)
    ci(2'h2);
    thread0_run = 1'b0;
    typ(2'h2, "D");
    `CHK("irq", 1'b0, comm_irq)
    thread0_run = 1'b1;
    typ(2'h2, "E");
    `CHK("irq", 1'b1, comm_irq)
    ret(1'b0);
    ci(2'h3);
    `CHK("status", 3'h0, rx_status_code)
    typ(2'h2, "Z");
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("string", 48'h5A0000000000, rx_string)
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_BSL);
    @(negedge sys_clk);
    `CHK("status", 3'h7, rx_status_code)
    cfg(2'h2, 8'h00);
    @(negedge sys_clk);
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_ESC);
    @(negedge sys_clk);
    `CHK("status", 3'h7, rx_status_code)
    `CHK("mode", 1'b0, mode_active)
    input_req = 1'b1;
    typ(2'h2, "7");
    `CHK("stall", 1'b1, prog_stall)
    `CHK("done", 1'b0, input_done)
    i_aoe_term_model.send(2'h2, aoe_pkg::CHAR_CR);
    `CHK("done", 1'b1, input_done)
    `CHK("value", 32'h00000007, input_value)
    `CHK("stall", 1'b0, prog_stall)
    input_req = 1'b0;
    nrst = 1'b0;
    @(negedge sys_clk);
    `CHK("status", 3'h7, rx_status_code)
    `CHK("string", 48'h000000000000, rx_string)
    `CHK("number", 32'h00000000, rx_number)
    nrst = 1'b1;
    @(negedge sys_clk);
    `CHK("mode", 1'b0, mode_active)
    complete_run();
  end
endmodule
